// file: hw/mcr_config_regs.sv
// Meter configuration and calibration register bank with serial command port
// Operation
// - Command 110 plus selector starts calibration
// - Current-only selectors 01001 01010 01101 01110
// - Voltage-only selectors 10001 10010 10101 10110
// - Both-channel selectors 11001 11010 11101 11110
// - Page 1 addresses 0-3 select four registers
// - Page 3 addresses 6,7,10,11 select sag/fault
// - Phase compensation is signed seven-bit field
// - Bit 16 selects current gain 10/50
// - Bit 15 makes pulse outputs open-drain
// - Bits 12,11 select interrupt pin style
// - Bit 4 inverts processor clock output
// - Divider field divides master clock, 0=16
// - DC offsets reset zero, calibration loads them
// - DC offsets are signed 24-bit fractions
// - Gains reset unity, calibration loads them
// - Gains unsigned, point after second bit
// - Command 0,W/R,address,0; write after 24 bits
// - Cycle count sets computation cycle length
`timescale 1ns/1ps
module mcr_config_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic serialClk,
  input wire logic serialCs_n,
  input wire logic serialIn,
  output logic serialOut,
  input wire logic calDone,
  input wire logic [23:0] measCurOffset,
  input wire logic [23:0] measVoltOffset,
  input wire logic [23:0] measCurGain,
  input wire logic [23:0] measVoltGain,
  input wire logic energyPulseA,
  input wire logic energyPulseB,
  output logic energy_pulse_out_a,
  output logic energy_pulse_out_a_oe,
  output logic energy_pulse_out_b,
  output logic energy_pulse_out_b_oe,
  input wire logic irqEvent,
  output logic irqPin,
  output logic processor_clock_out,
  output logic internalClkEn,
  output logic calStart,
  output logic calCurrent,
  output logic calVoltage,
  output mcr_pkg::mcr_cal_kind_t calKind,
  output logic calBusy,
  output logic data_ready_flag,
  output logic [6:0] phase_comp_field,
  output logic currentGainHigh,
  output logic [23:0] cycleCount
);
  // Synchronisers for the serial pins
  logic [1:0] sclkSync;
  logic [1:0] csSync;
  logic [1:0] sdiSync;
  logic sclkLast;
  // Serial framing state
  logic [7:0] cmdShift;
  logic [2:0] cmdBits;
  logic cmdValid;
  logic [23:0] dataShift;
  logic [4:0] dataBits;
  logic writeCmd;
  logic [4:0] register_address_bits;
  logic [23:0] readShift;
  // Register storage
  logic [23:0] configuration;
  logic [23:0] current_dc_offset;
  logic [23:0] voltage_dc_offset;
  logic [23:0] current_gain_cal;
  logic [23:0] voltage_gain_cal;
  logic [23:0] cycleCountReg;
  logic [1:0] pageSel;
  logic [23:0] energy_pulse_width;
  logic [23:0] noLoadThreshold;
  logic [23:0] tempSensorGain;
  logic [23:0] tempSensorOffset;
  logic [23:0] voltageSagDuration;
  logic [23:0] voltageSagLevel;
  logic [23:0] currentFaultDuration;
  logic [23:0] currentFaultLevel;
  // Divider and clock output
  logic [3:0] divCount;
  logic divClkPhase;
  // Interrupt pin pulse tracking
  logic irqLast;

  // Edges seen on synchronised serial clock
  wire sclkRise = sclkSync[1] & ~sclkLast;
  wire sclkFall = ~sclkSync[1] & sclkLast;
  wire csActive = ~csSync[1];
  wire [7:0] cmdByte = {cmdShift[6:0], sdiSync[1]};
  wire cmdLast = sclkRise && csActive && !cmdValid && (cmdBits == 3'h7);
  wire dataLast = sclkRise && csActive && cmdValid && (dataBits == mcr_pkg::WORD_BITS - 5'h01);
  wire isCalCmd = cmdByte[7:5] == mcr_pkg::CMD_CAL_PREFIX;
  wire isRegCmd = (cmdByte[7] == 1'b0) && (cmdByte[0] == 1'b0);
  wire [4:0] calSel = cmdByte[4:0];
  wire [23:0] writeWord = {dataShift[22:0], sdiSync[1]};
  wire selCurrent = (calSel[4:3] == 2'b01) || (calSel[4:3] == 2'b11);
  wire selVoltage = calSel[4];
  wire selDcOff = calSel[2:0] == 3'h1;
  wire selAcOff = calSel[2:0] == 3'h5;
  wire selGain = (calSel[1:0] == 2'h2);
  wire calGo = cmdLast && isCalCmd && (calSel[4] | calSel[3]);

  // Read multiplexer by page and address
  function automatic logic [23:0] read_mux(input logic [1:0] pg, input logic [4:0] a);
    logic [23:0] v;
    v = 24'h000000;
    if (a == mcr_pkg::ADDR_PAGE) v = {22'h000000, pageSel};
    else if (pg == mcr_pkg::PAGE_0) begin
      unique case (a)
        mcr_pkg::ADDR_CONFIG: v = configuration;
        mcr_pkg::ADDR_CUR_DC_OFFSET: v = current_dc_offset;
        mcr_pkg::ADDR_CUR_GAIN: v = current_gain_cal;
        mcr_pkg::ADDR_VOLT_DC_OFFSET: v = voltage_dc_offset;
        mcr_pkg::ADDR_VOLT_GAIN: v = voltage_gain_cal;
        mcr_pkg::ADDR_CYCLE_COUNT: v = cycleCountReg;
        default: v = 24'h000000;
      endcase
    end else if (pg == mcr_pkg::PAGE_1) begin
      unique case (a)
        mcr_pkg::ADDR_PULSE_WIDTH: v = energy_pulse_width;
        mcr_pkg::ADDR_NO_LOAD: v = noLoadThreshold;
        mcr_pkg::ADDR_TEMP_GAIN: v = tempSensorGain;
        mcr_pkg::ADDR_TEMP_OFFSET: v = tempSensorOffset;
        default: v = 24'h000000;
      endcase
    end else if (pg == mcr_pkg::PAGE_3) begin
      unique case (a)
        mcr_pkg::ADDR_VSAG_DUR: v = voltageSagDuration;
        mcr_pkg::ADDR_VSAG_LVL: v = voltageSagLevel;
        mcr_pkg::ADDR_IFLT_DUR: v = currentFaultDuration;
        mcr_pkg::ADDR_IFLT_LVL: v = currentFaultLevel;
        default: v = 24'h000000;
      endcase
    end
    return v;
  endfunction

  // Write strobe after the 24th serial clock
  wire regWrite = dataLast && writeCmd;
  wire wrP0 = regWrite && pageSel == mcr_pkg::PAGE_0;
  wire wrP1 = regWrite && pageSel == mcr_pkg::PAGE_1;
  wire wrP3 = regWrite && pageSel == mcr_pkg::PAGE_3;

  // Two-stage synchronisers; first stage read only by second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclkSync <= 2'h0;
      csSync <= 2'h3;
      sdiSync <= 2'h0;
      sclkLast <= 1'b0;
    end else begin
      sclkSync <= {sclkSync[0], serialClk};
      csSync <= {csSync[0], serialCs_n};
      sdiSync <= {sdiSync[0], serialIn};
      sclkLast <= sclkSync[1];
    end
  end

  // Command and data shift framing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdShift <= 8'h00;
      cmdBits <= 3'h0;
      cmdValid <= 1'b0;
      dataShift <= 24'h000000;
      dataBits <= 5'h00;
      writeCmd <= 1'b0;
      register_address_bits <= 5'h00;
    end else if (!csActive) begin
      // Deselect abandons any partial frame
      cmdBits <= 3'h0;
      cmdValid <= 1'b0;
      dataBits <= 5'h00;
    end else if (sclkRise) begin
      if (!cmdValid) begin
        cmdShift <= cmdByte;
        cmdBits <= cmdBits + 3'h1;
        if (cmdLast && isRegCmd) begin
          cmdValid <= 1'b1;
          writeCmd <= cmdByte[6];
          register_address_bits <= cmdByte[5:1];
          dataBits <= 5'h00;
        end
      end else begin
        dataShift <= writeWord;
        dataBits <= dataBits + 5'h01;
        if (dataLast) cmdValid <= 1'b0;
      end
    end
  end

  // Read buffer loads at command end, shifts on falling clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readShift <= 24'h000000;
    end else if (cmdLast && isRegCmd && !cmdByte[6]) begin
      readShift <= read_mux(pageSel, cmdByte[5:1]);
    end else if (sclkFall && cmdValid && !writeCmd && dataBits != 5'h00) begin
      readShift <= {readShift[22:0], 1'b0};
    end
  end
  assign serialOut = readShift[23];

  // Configuration, page select and general registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      configuration <= mcr_pkg::CONFIG_RESET;
      cycleCountReg <= mcr_pkg::CYCLE_COUNT_RESET;
      pageSel <= mcr_pkg::PAGE_0;
      energy_pulse_width <= 24'h000000;
      noLoadThreshold <= 24'h000000;
      tempSensorGain <= 24'h000000;
      tempSensorOffset <= 24'h000000;
      voltageSagDuration <= 24'h000000;
      voltageSagLevel <= 24'h000000;
      currentFaultDuration <= 24'h000000;
      currentFaultLevel <= 24'h000000;
    end else if (regWrite) begin
      if (register_address_bits == mcr_pkg::ADDR_PAGE) pageSel <= writeWord[1:0];
      if (wrP0 && register_address_bits == mcr_pkg::ADDR_CONFIG)
        configuration <= writeWord & mcr_pkg::CONFIG_WMASK;
      if (wrP0 && register_address_bits == mcr_pkg::ADDR_CYCLE_COUNT) cycleCountReg <= writeWord;
      if (wrP1 && register_address_bits == mcr_pkg::ADDR_PULSE_WIDTH) energy_pulse_width <= writeWord;
      if (wrP1 && register_address_bits == mcr_pkg::ADDR_NO_LOAD) noLoadThreshold <= writeWord;
      if (wrP1 && register_address_bits == mcr_pkg::ADDR_TEMP_GAIN) tempSensorGain <= writeWord;
      if (wrP1 && register_address_bits == mcr_pkg::ADDR_TEMP_OFFSET) tempSensorOffset <= writeWord;
      if (wrP3 && register_address_bits == mcr_pkg::ADDR_VSAG_DUR) voltageSagDuration <= writeWord;
      if (wrP3 && register_address_bits == mcr_pkg::ADDR_VSAG_LVL) voltageSagLevel <= writeWord;
      if (wrP3 && register_address_bits == mcr_pkg::ADDR_IFLT_DUR) currentFaultDuration <= writeWord;
      if (wrP3 && register_address_bits == mcr_pkg::ADDR_IFLT_LVL) currentFaultLevel <= writeWord;
    end
  end

  // Calibration sequencing and result registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      current_dc_offset <= mcr_pkg::OFFSET_RESET;
      voltage_dc_offset <= mcr_pkg::OFFSET_RESET;
      current_gain_cal <= mcr_pkg::GAIN_RESET;
      voltage_gain_cal <= mcr_pkg::GAIN_RESET;
      calBusy <= 1'b0;
      calCurrent <= 1'b0;
      calVoltage <= 1'b0;
      calKind <= mcr_pkg::MCR_CAL_DC_OFF;
      data_ready_flag <= 1'b0;
    end else begin
      if (calGo) begin
        calBusy <= 1'b1;
        calCurrent <= selCurrent;
        calVoltage <= selVoltage;
        calKind <= selGain ? mcr_pkg::MCR_CAL_GAIN
          : selAcOff ? mcr_pkg::MCR_CAL_AC_OFF : mcr_pkg::MCR_CAL_DC_OFF;
        // Completion in the same cycle wins over the clear
        data_ready_flag <= calBusy && calDone;
      end else if (calBusy && calDone) begin
        calBusy <= 1'b0;
        data_ready_flag <= 1'b1;
        if (calKind == mcr_pkg::MCR_CAL_DC_OFF && calCurrent) current_dc_offset <= measCurOffset;
        if (calKind == mcr_pkg::MCR_CAL_DC_OFF && calVoltage) voltage_dc_offset <= measVoltOffset;
        if (calKind == mcr_pkg::MCR_CAL_GAIN && calCurrent) current_gain_cal <= measCurGain;
        if (calKind == mcr_pkg::MCR_CAL_GAIN && calVoltage) voltage_gain_cal <= measVoltGain;
      end else if (wrP0) begin
        // offsets stored raw as signed fractions
        if (register_address_bits == mcr_pkg::ADDR_CUR_DC_OFFSET) current_dc_offset <= writeWord;
        if (register_address_bits == mcr_pkg::ADDR_VOLT_DC_OFFSET) voltage_dc_offset <= writeWord;
        if (register_address_bits == mcr_pkg::ADDR_CUR_GAIN) current_gain_cal <= writeWord;
        if (register_address_bits == mcr_pkg::ADDR_VOLT_GAIN) voltage_gain_cal <= writeWord;
      end
    end
  end
  assign calStart = calGo;

  // Config field outputs
  // phase compensation passed as signed code
  assign phase_comp_field = configuration[mcr_pkg::PC_HI:mcr_pkg::PC_LO];
  assign currentGainHigh = configuration[mcr_pkg::IGAIN_BIT];
  assign cycleCount = cycleCountReg;

  // divider, code zero divides by sixteen
  wire [3:0] divLimit = configuration[mcr_pkg::DIV_HI:mcr_pkg::DIV_LO] - 4'h1;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divCount <= 4'h0;
      divClkPhase <= 1'b0;
    end else if (divCount >= divLimit) begin
      divCount <= 4'h0;
      divClkPhase <= ~divClkPhase;
    end else begin
      divCount <= divCount + 4'h1;
    end
  end
  assign internalClkEn = divCount >= divLimit;
  assign processor_clock_out = divClkPhase ^ configuration[mcr_pkg::CLK_INV_BIT];

  // open-drain pulse pins drive low only
  wire openDrain = configuration[mcr_pkg::OPEN_DRAIN_BIT];
  assign energy_pulse_out_a = energyPulseA;
  assign energy_pulse_out_b = energyPulseB;
  assign energy_pulse_out_a_oe = ~openDrain | ~energyPulseA;
  assign energy_pulse_out_b_oe = ~openDrain | ~energyPulseB;

  // interrupt pin style, pulses last one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) irqLast <= 1'b0;
    else irqLast <= irqEvent;
  end
  wire irqEdge = irqEvent & ~irqLast;
  wire irqAct = configuration[mcr_pkg::IRQ_PULSE_BIT] ? irqEdge : irqEvent;
  assign irqPin = irqAct ^ ~configuration[mcr_pkg::IRQ_INV_BIT];
endmodule // mcr_config_regs

// file: hw/mcr_pkg.sv
// Package: register map, field layout, reset values and command codes
package mcr_pkg;
  // Register and command widths
  localparam int DATA_W = 24;
  localparam int ADDR_W = 5;
  // Page numbers held in the page select register
  localparam logic [1:0] PAGE_0 = 2'h0;
  localparam logic [1:0] PAGE_1 = 2'h1;
  localparam logic [1:0] PAGE_3 = 2'h3;
  // Page 0 addresses
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_CUR_DC_OFFSET = 5'h01;
  localparam logic [4:0] ADDR_CUR_GAIN = 5'h02;
  localparam logic [4:0] ADDR_VOLT_DC_OFFSET = 5'h03;
  localparam logic [4:0] ADDR_VOLT_GAIN = 5'h04;
  localparam logic [4:0] ADDR_CYCLE_COUNT = 5'h05;
  localparam logic [4:0] ADDR_PAGE = 5'h1F;
  // Page 1 addresses
  localparam logic [4:0] ADDR_PULSE_WIDTH = 5'h00;
  localparam logic [4:0] ADDR_NO_LOAD = 5'h01;
  localparam logic [4:0] ADDR_TEMP_GAIN = 5'h02;
  localparam logic [4:0] ADDR_TEMP_OFFSET = 5'h03;
  // Page 3 addresses
  localparam logic [4:0] ADDR_VSAG_DUR = 5'h06;
  localparam logic [4:0] ADDR_VSAG_LVL = 5'h07;
  localparam logic [4:0] ADDR_IFLT_DUR = 5'h0A;
  localparam logic [4:0] ADDR_IFLT_LVL = 5'h0B;
  // Reset values
  localparam logic [23:0] CONFIG_RESET = 24'h000001;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_RESET = 24'h400000;
  localparam logic [23:0] CYCLE_COUNT_RESET = 24'h000FA0;
  localparam logic [23:0] PAGE_REG_RESET = 24'h000000;
  // Configuration field positions
  localparam int PC_HI = 23;
  localparam int PC_LO = 17;
  localparam int IGAIN_BIT = 16;
  localparam int OPEN_DRAIN_BIT = 15;
  localparam int IRQ_PULSE_BIT = 12;
  localparam int IRQ_INV_BIT = 11;
  localparam int CLK_INV_BIT = 4;
  localparam int DIV_HI = 3;
  localparam int DIV_LO = 0;
  // Writable configuration bits; reserved positions read zero
  localparam logic [23:0] CONFIG_WMASK = 24'hFF981F;
  // Command byte framing
  localparam logic [2:0] CMD_CAL_PREFIX = 3'h6;
  localparam logic [4:0] CAL_I_DC_OFF = 5'h09;
  localparam logic [4:0] CAL_I_DC_GAIN = 5'h0A;
  localparam logic [4:0] CAL_I_AC_OFF = 5'h0D;
  localparam logic [4:0] CAL_I_AC_GAIN = 5'h0E;
  localparam logic [4:0] CAL_V_DC_OFF = 5'h11;
  localparam logic [4:0] CAL_V_DC_GAIN = 5'h12;
  localparam logic [4:0] CAL_V_AC_OFF = 5'h15;
  localparam logic [4:0] CAL_V_AC_GAIN = 5'h16;
  localparam logic [4:0] CAL_B_DC_OFF = 5'h19;
  localparam logic [4:0] CAL_B_DC_GAIN = 5'h1A;
  localparam logic [4:0] CAL_B_AC_OFF = 5'h1D;
  localparam logic [4:0] CAL_B_AC_GAIN = 5'h1E;
  // Serial data bits per register word
  localparam logic [4:0] WORD_BITS = 5'h18;
  // Calibration kind
  typedef enum logic [1:0] {
    MCR_CAL_DC_OFF,
    MCR_CAL_AC_OFF,
    MCR_CAL_GAIN
  } mcr_cal_kind_t;
endpackage

// file: test/mcr_host_model.sv
// Host processor model driving the serial command port
`timescale 1ns/1ps
module mcr_host_model (
  input wire logic clk,
  output logic serialClk,
  output logic serialCs_n,
  output logic serialIn,
  input wire logic serialOut
);
  // Serial clock parked low, chip deselected
  initial begin
    serialClk = 1'b0;
    serialCs_n = 1'b1;
    serialIn = 1'b0;
  end
  // Whole clk cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [23:0] wdata, input logic withData,
                       output logic [23:0] rdata);
    logic [31:0] bits;
    int nBits;
    bits = {cmd, wdata};
    nBits = withData ? 32 : 8;
    rdata = 24'h000000;
    serialCs_n = 1'b0;
    tick(4);
    // Half periods of 4 clk keep above the 3-cycle sync floor
    for (int i = 0; i < nBits; i++) begin
      serialIn = bits[31 - i];
      tick(4);
      if (i >= 8) rdata = {rdata[22:0], serialOut};
      serialClk = 1'b1;
      tick(4);
      serialClk = 1'b0;
    end
    // Hold select past the write landing
    tick(8);
    serialCs_n = 1'b1;
    // Released line shows no stale bit
    serialIn = ~serialIn;
    tick(4);
  endtask
endmodule // mcr_host_model

// file: test/mcr_config_regs_monitor.sv
// Port checker for the configuration and calibration register bank
`timescale 1ns/1ps
module mcr_config_regs_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic serialCs_n,
  input wire logic calDone,
  input wire logic energyPulseA,
  input wire logic energyPulseB,
  input wire logic energy_pulse_out_a_oe,
  input wire logic energy_pulse_out_b_oe,
  input wire logic internalClkEn,
  input wire logic calStart,
  input wire logic calCurrent,
  input wire logic calVoltage,
  input wire logic calBusy,
  input wire logic data_ready_flag,
  input wire logic [6:0] phase_comp_field
);
  // Cycles since the last divided clock enable, saturating
  logic [4:0] gapCount;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gapCount <= 5'h00;
    end else if (internalClkEn) begin
      gapCount <= 5'h00;
    end else if (gapCount != 5'h1F) begin
      gapCount <= gapCount + 5'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_accept; calStart ##1 !calStart; endsequence
  sequence s_finish; calDone && calBusy; endsequence
  property p_cal_pulse; calStart |-> s_accept; endproperty
  a_cal_pulse: assert property (p_cal_pulse)
    else $error("calibration start wider than one cycle");
  property p_cal_busy; s_accept |-> ##[0:1] calBusy; endproperty
  a_cal_busy: assert property (p_cal_busy)
    else $error("calibration accepted without busy");
  property p_ready_clear; calStart && !(calDone && calBusy) |-> ##1 !data_ready_flag; endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("data ready not cleared by calibration start");
  property p_ready_set; s_finish |-> ##[1:2] data_ready_flag; endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("data ready not set after calibration");
  property p_channel; calBusy |-> (calCurrent || calVoltage); endproperty
  a_channel: assert property (p_channel)
    else $error("calibration busy with no channel");
  // Longest divisor is 16, so at most 15 idle cycles
  property p_div_gap; gapCount <= 5'h0F; endproperty
  a_div_gap: assert property (p_div_gap)
    else $error("divided clock enable gap too long");
  property p_oe_a; !energy_pulse_out_a_oe |-> energyPulseA; endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("pulse pin a released while low");
  property p_oe_b; !energy_pulse_out_b_oe |-> energyPulseB; endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("pulse pin b released while low");
  property p_cfg_frame; !$stable(phase_comp_field) |-> !$past(serialCs_n, 3); endproperty
  a_cfg_frame: assert property (p_cfg_frame)
    else $error("configuration changed outside a frame");
endmodule // mcr_config_regs_monitor
bind mcr_config_regs mcr_config_regs_monitor mcr_config_regs_monitor_i (
  .clk(clk), .reset(reset), .serialCs_n(serialCs_n), .calDone(calDone),
  .energyPulseA(energyPulseA), .energyPulseB(energyPulseB),
  .energy_pulse_out_a_oe(energy_pulse_out_a_oe), .energy_pulse_out_b_oe(energy_pulse_out_b_oe),
  .internalClkEn(internalClkEn), .calStart(calStart), .calCurrent(calCurrent),
  .calVoltage(calVoltage), .calBusy(calBusy), .data_ready_flag(data_ready_flag),
  .phase_comp_field(phase_comp_field)
);

// file: test/testbench.sv
// Self-checking bench for the configuration and calibration register bank
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, reset = 1'b1, serialClk, serialCs_n, serialIn, serialOut, calDone = 1'b0;
  logic [23:0] measCurOffset = 24'h0, measVoltOffset = 24'h0;
  logic [23:0] measCurGain = 24'h0, measVoltGain = 24'h0, cycleCount, got;
  logic energyPulseA = 1'b1, energyPulseB = 1'b1, irqEvent = 1'b0, irqPin;
  logic outA, oeA, outB, oeB, procClk, internalClkEn, calStart, calCurrent, calVoltage, calBusy;
  logic data_ready_flag, currentGainHigh;
  logic [6:0] phase_comp_field;
  mcr_pkg::mcr_cal_kind_t calKind, expKind;
  logic [23:0] expReg [5] = '{24'h0, 24'h0, 24'h400000, 24'h0, 24'h400000};
  logic [4:0] p3Addr [4] = '{mcr_pkg::ADDR_VSAG_DUR, mcr_pkg::ADDR_VSAG_LVL,
                             mcr_pkg::ADDR_IFLT_DUR, mcr_pkg::ADDR_IFLT_LVL};
  logic [4:0] codes [12] = '{5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h11, 5'h12, 5'h15, 5'h16,
                             5'h19, 5'h1A, 5'h1D, 5'h1E};
  int fails = 0, checkCount = 0;
  // Divided clock phase reference: one toggle per divided period
  logic refPhase;
  // Free-running 40 MHz clock
  always #12.5 clk = ~clk;
  always @(posedge clk or posedge reset) begin
    if (reset) refPhase <= 1'b0;
    else if (internalClkEn) refPhase <= ~refPhase;
  end
  mcr_config_regs mcr_config_regs_i (
    .clk(clk), .reset(reset), .serialClk(serialClk), .serialCs_n(serialCs_n),
    .serialIn(serialIn), .serialOut(serialOut), .calDone(calDone),
    .measCurOffset(measCurOffset), .measVoltOffset(measVoltOffset),
    .measCurGain(measCurGain), .measVoltGain(measVoltGain),
    .energyPulseA(energyPulseA), .energyPulseB(energyPulseB),
    .energy_pulse_out_a(outA), .energy_pulse_out_a_oe(oeA),
    .energy_pulse_out_b(outB), .energy_pulse_out_b_oe(oeB), .irqEvent(irqEvent),
    .irqPin(irqPin), .processor_clock_out(procClk), .internalClkEn(internalClkEn),
    .calStart(calStart), .calCurrent(calCurrent), .calVoltage(calVoltage), .calKind(calKind),
    .calBusy(calBusy), .data_ready_flag(data_ready_flag), .phase_comp_field(phase_comp_field),
    .currentGainHigh(currentGainHigh), .cycleCount(cycleCount)
  );
  mcr_host_model mcr_host_model_i (
    .clk(clk), .serialClk(serialClk), .serialCs_n(serialCs_n),
    .serialIn(serialIn), .serialOut(serialOut)
  );
  // Verdict and end of run
  task automatic test_done();
    if (fails == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [4:0] addr, input logic [23:0] data);
    host_frame({2'b01, addr, 1'b0}, data, 1'b1);
  endtask
  task automatic host_frame(input logic [7:0] cmd, input logic [23:0] data, input logic full);
    mcr_host_model_i.frame(cmd, data, full, got);
  endtask
  task automatic rdChk(input string what, input logic [4:0] addr, input logic [23:0] exp);
    host_frame({2'b00, addr, 1'b0}, 24'h000000, 1'b1);
    check(what, got, exp);
  endtask
  // Period between enables must equal the divisor
  task automatic divChk(input logic [3:0] k, input int exp);
    int gap;
    wr(mcr_pkg::ADDR_CONFIG, {20'h00000, k});
    for (int i = 0; i < 40 && internalClkEn !== 1'b1; i++) step();
    gap = 0;
    do begin
      step();
      gap++;
    end while (internalClkEn !== 1'b1 && gap < 40);
    check("divider period", 24'(gap), 24'(exp));
    check("proc clock", {23'h0, procClk}, {23'h0, refPhase});
  endtask
  // Hang guard, well past the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    #2 reset = 1'b0;
    repeat (3) step();
    rdChk("config reset", mcr_pkg::ADDR_CONFIG, 24'h000001);
    for (int a = 1; a < 5; a++) rdChk("cal reset", a[4:0], expReg[a]);
    check("cycle count", cycleCount, 24'h000FA0);
    wr(mcr_pkg::ADDR_CYCLE_COUNT, 24'h000123);
    check("cycle count wr", cycleCount, 24'h000123);
    divChk(4'h1, 1);
    divChk(4'h3, 3);
    divChk(4'h0, 16);
    wr(mcr_pkg::ADDR_CONFIG, 24'hFF9813);
    rdChk("config fields", mcr_pkg::ADDR_CONFIG, 24'hFF9813);
    check("phase comp", {17'h0, phase_comp_field}, 24'h00007F);
    check("current gain", {23'h0, currentGainHigh}, 24'h000001);
    check("proc clock inv", {23'h0, procClk}, {23'h0, !refPhase});
    // Open-drain select against both pulse levels
    for (int m = 0; m < 4; m++) begin
      wr(mcr_pkg::ADDR_CONFIG, {8'h00, m[1], 15'h0001});
      energyPulseA = m[0];
      energyPulseB = !m[0];
      step();
      check("pulse a drive", {23'h0, oeA}, {23'h0, !m[1] || !m[0]});
      check("pulse b drive", {23'h0, oeB}, {23'h0, !m[1] || m[0]});
      check("pulse a level", {23'h0, outA}, {23'h0, m[0]});
      check("pulse b level", {23'h0, outB}, {23'h0, !m[0]});
    end
    // Every interrupt style: idle, then held event
    for (int m = 0; m < 4; m++) begin
      wr(mcr_pkg::ADDR_CONFIG, {11'h000, m[1:0], 11'h001});
      check("irq idle", {23'h0, irqPin}, {23'h0, !m[0]});
      irqEvent = 1'b1;
      #1;
      check("irq active", {23'h0, irqPin}, {23'h0, m[0]});
      repeat (3) step();
      check("irq held", {23'h0, irqPin}, {23'h0, m[1] ? !m[0] : m[0]});
      irqEvent = 1'b0;
      step();
    end
    wr(mcr_pkg::ADDR_PAGE, {22'h0, mcr_pkg::PAGE_1});
    for (int a = 0; a < 4; a++) wr(a[4:0], 24'hA50000 + 24'(a));
    for (int a = 0; a < 4; a++) rdChk("page1 reg", a[4:0], 24'hA50000 + 24'(a));
    wr(mcr_pkg::ADDR_PAGE, {22'h0, mcr_pkg::PAGE_3});
    for (int a = 0; a < 4; a++) wr(p3Addr[a], 24'h5A0000 + 24'(a));
    for (int a = 0; a < 4; a++) rdChk("page3 reg", p3Addr[a], 24'h5A0000 + 24'(a));
    rdChk("page3 hole", 5'h00, 24'h000000);
    wr(mcr_pkg::ADDR_PAGE, {22'h0, mcr_pkg::PAGE_0});
    rdChk("config kept", mcr_pkg::ADDR_CONFIG, 24'h001801);
    // All twelve calibration codes with signed and full-scale results
    for (int i = 0; i < 12; i++) begin
      measCurOffset = 24'h800000 + 24'(i);
      measVoltOffset = 24'h7FFFF0 + 24'(i);
      measCurGain = 24'hFFFFF0 + 24'(i);
      measVoltGain = 24'h000100 + 24'(i);
      expKind = (codes[i][2:0] == 3'h1) ? mcr_pkg::MCR_CAL_DC_OFF :
                (codes[i][2:0] == 3'h5) ? mcr_pkg::MCR_CAL_AC_OFF : mcr_pkg::MCR_CAL_GAIN;
      host_frame({mcr_pkg::CMD_CAL_PREFIX, codes[i]}, 24'h000000, 1'b0);
      check("cal current", {23'h0, calCurrent}, {23'h0, codes[i][3]});
      check("cal voltage", {23'h0, calVoltage}, {23'h0, codes[i][4]});
      check("cal kind", {22'h0, calKind}, {22'h0, expKind});
      check("cal busy", {22'h0, calBusy, data_ready_flag}, 24'h000002);
      calDone = 1'b1;
      step();
      calDone = 1'b0;
      repeat (2) step();
      check("cal finish", {22'h0, calBusy, data_ready_flag}, 24'h000001);
      if (expKind == mcr_pkg::MCR_CAL_DC_OFF && codes[i][3]) expReg[1] = measCurOffset;
      if (expKind == mcr_pkg::MCR_CAL_DC_OFF && codes[i][4]) expReg[3] = measVoltOffset;
      if (expKind == mcr_pkg::MCR_CAL_GAIN && codes[i][3]) expReg[2] = measCurGain;
      if (expKind == mcr_pkg::MCR_CAL_GAIN && codes[i][4]) expReg[4] = measVoltGain;
      for (int a = 1; a < 5; a++) rdChk("cal result", a[4:0], expReg[a]);
    end
    test_done();
  end
endmodule // testbench
